// File: rtl/psdt_defs.svh
// Purpose: offsets, field positions and reset values for the power state
//   descriptor table
// Assumes: 32-bit register port, word offsets are byte addresses
// Notes: definitions only
`ifndef PSDT_DEFS_SVH
`define PSDT_DEFS_SVH
// descriptor field positions
`define PSDT_RWL_LSB 120
`define PSDT_RWT_LSB 112
`define PSDT_RRL_LSB 104
`define PSDT_RRT_LSB 96
`define PSDT_EXIT_LATENCY_US_LSB 64
`define PSDT_ENTRY_LATENCY_US_LSB 32
`define PSDT_NON_OPERATIONAL_FLAG_BIT 25
`define PSDT_MPS_BIT 24
`define PSDT_MP_LSB 0
`define PSDT_RANK_W 5
`define PSDT_DESC_W 256
`define PSDT_MAX_STATES 32
// register offsets (byte addresses)
`define PSDT_OFS_SEL 8'h00
`define PSDT_OFS_RANK 8'h04
`define PSDT_OFS_EXIT_LATENCY_US 8'h08
`define PSDT_OFS_ENTRY_LATENCY_US 8'h0c
`define PSDT_OFS_POWER 8'h10
`define PSDT_OFS_COUNT 8'h14
`define PSDT_OFS_RDSEL 8'h18
`define PSDT_OFS_RDDAT 8'h1c
`define PSDT_OFS_STAT 8'h20
// power register field positions
`define PSDT_PWR_NON_OPERATIONAL_FLAG_BIT 17
`define PSDT_PWR_MPS_BIT 16
// reset values
`define PSDT_RST_COUNT 6'h01
`endif

// File: rtl/psdt_desc_pack.sv
// Purpose: packs one state's fields into its 256-bit descriptor
// Assumes: fields already range-checked by the caller
// Notes: purely combinational
`timescale 1ns/1ns
`include "psdt_defs.svh"
module psdt_desc_pack (
  // descriptor fields
  input wire logic [4:0] i_rwl,
  input wire logic [4:0] i_rwt,
  input wire logic [4:0] i_rrl,
  input wire logic [4:0] i_rrt,
  input wire logic [31:0] i_exit_latency_us,
  input wire logic [31:0] i_entry_latency_us,
  input wire logic i_non_operational_flag,
  input wire logic i_mps,
  input wire logic [15:0] i_mp,
  input wire logic i_valid,
  // packed result
  output logic [255:0] o_desc
);
  // every bit not named below stays zero, reserved ranges included
  always_comb begin
    o_desc = '0;
    if (i_valid) begin
      o_desc[`PSDT_RWL_LSB +: 5] = i_rwl;
      o_desc[`PSDT_RWT_LSB +: 5] = i_rwt;
      o_desc[`PSDT_RRL_LSB +: 5] = i_rrl;
      o_desc[`PSDT_RRT_LSB +: 5] = i_rrt;
      o_desc[`PSDT_EXIT_LATENCY_US_LSB +: 32] = i_exit_latency_us;
      o_desc[`PSDT_ENTRY_LATENCY_US_LSB +: 32] = i_entry_latency_us;
      o_desc[`PSDT_NON_OPERATIONAL_FLAG_BIT] = i_non_operational_flag;
      o_desc[`PSDT_MPS_BIT] = i_mps;
      o_desc[`PSDT_MP_LSB +: 16] = i_mp;
    end
  end
endmodule : psdt_desc_pack

// File: rtl/psdt_pkg.sv
// Purpose: types shared by the descriptor table files
// Assumes: nothing
// Notes: constants live in psdt_defs.svh
package psdt_pkg;
  typedef logic [4:0] psdt_idx_t;
  typedef logic [255:0] psdt_desc_t;
  typedef enum logic [1:0] {
    PSDT_IDLE = 2'b00,
    PSDT_LOAD = 2'b01
  } psdt_st_e;
endpackage : psdt_pkg

// File: rtl/psdt_table.sv
// Purpose: power state descriptor store with a register port, read out
//   per descriptor word by software and as one descriptor by the host path
// Assumes: single 100 MHz clock, register port never waits
// Notes: out-of-range ranks are clamped so a bad write cannot leak out
`timescale 1ns/1ns
`include "psdt_defs.svh"
module psdt_table #(
  parameter int NUM_STATES = `PSDT_MAX_STATES
) (
  // clock, reset, enable
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // register port
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // host descriptor read path
  input wire psdt_pkg::psdt_idx_t i_desc_idx,
  output psdt_pkg::psdt_desc_t o_desc,
  // current state attributes
  input wire psdt_pkg::psdt_idx_t i_cur_state,
  output logic o_io_blocked
);
  import psdt_pkg::*;

  // the state index is five bits wide, so the depth stops at 32
  if (NUM_STATES < 1 || NUM_STATES > `PSDT_MAX_STATES) begin : g_bad_depth
    $error("NUM_STATES must lie in 1..32");
  end

  // per-state storage, flip-flops addressed by state index
  logic [4:0] rwl_reg [NUM_STATES];
  logic [4:0] rwt_reg [NUM_STATES];
  logic [4:0] rrl_reg [NUM_STATES];
  logic [4:0] rrt_reg [NUM_STATES];
  logic [31:0] exit_latency_us_reg [NUM_STATES];
  logic [31:0] entry_latency_us_reg [NUM_STATES];
  logic non_operational_flag_reg [NUM_STATES];
  logic mps_reg [NUM_STATES];
  logic [15:0] mp_reg [NUM_STATES];
  psdt_idx_t sel_reg;
  logic [5:0] count_reg;
  logic [2:0] rdsel_reg;
  logic clamp_reg;
  logic [31:0] rdata_reg;
  psdt_desc_t desc_reg;
  logic io_blk_reg;
  psdt_desc_t sw_desc;
  psdt_desc_t host_desc;

  // register address decode, used by the write paths; the read path decodes with its own case
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // a rank must stay below the count of supported states
  function automatic logic [4:0] clamp_rank(input logic [4:0] v,
                                            input logic [5:0] cnt);
    if ({1'b0, v} < cnt) begin
      clamp_rank = v;
    end else begin
      clamp_rank = 5'(cnt - 6'h01);
    end
  endfunction : clamp_rank

  // selection, supported-state count and word select
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sel_reg <= '0;
      count_reg <= `PSDT_RST_COUNT;
      rdsel_reg <= 3'h0;
    end else if (i_ce && i_wr) begin
      if (hit(i_addr, `PSDT_OFS_SEL)) begin
        sel_reg <= i_wdata[4:0];
      end
      if (hit(i_addr, `PSDT_OFS_COUNT)) begin
        // zero states would make every rank illegal; a count above NUM_STATES is capped at NUM_STATES
        if (i_wdata[5:0] == 6'h00) begin
          count_reg <= 6'h01;
        end else if (i_wdata[5:0] > 6'(NUM_STATES)) begin
          count_reg <= 6'(NUM_STATES);
        end else begin
          count_reg <= i_wdata[5:0];
        end
      end
      if (hit(i_addr, `PSDT_OFS_RDSEL)) begin
        rdsel_reg <= i_wdata[2:0];
      end
    end
  end

  // sticky flag: a rank write was clamped; cleared by writing one
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      clamp_reg <= 1'b0;
    end else if (i_ce) begin
      if (i_wr && hit(i_addr, `PSDT_OFS_RANK) &&
          ({1'b0, i_wdata[28:24]} >= count_reg ||
           {1'b0, i_wdata[20:16]} >= count_reg ||
           {1'b0, i_wdata[12:8]} >= count_reg ||
           {1'b0, i_wdata[4:0]} >= count_reg)) begin
        clamp_reg <= 1'b1; // set wins over a same-cycle clear
      end else if (i_wr && hit(i_addr, `PSDT_OFS_STAT) && i_wdata[0]) begin
        clamp_reg <= 1'b0;
      end
    end
  end

  // per-state field storage, one generate slice per power state
  for (genvar s = 0; s < NUM_STATES; s++) begin : g_state
    logic wr_me;
    assign wr_me = i_ce && i_wr && (sel_reg == 5'(s));
    always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        rwl_reg[s] <= 5'h00;
        rwt_reg[s] <= 5'h00;
        rrl_reg[s] <= 5'h00;
        rrt_reg[s] <= 5'h00;
        exit_latency_us_reg[s] <= 32'h0;
        entry_latency_us_reg[s] <= 32'h0;
        non_operational_flag_reg[s] <= 1'b0;
        mps_reg[s] <= 1'b0;
        mp_reg[s] <= 16'h0;
      end else if (wr_me) begin
        if (hit(i_addr, `PSDT_OFS_RANK)) begin
          rwl_reg[s] <= clamp_rank(i_wdata[28:24], count_reg);
          rwt_reg[s] <= clamp_rank(i_wdata[20:16], count_reg);
          rrl_reg[s] <= clamp_rank(i_wdata[12:8], count_reg);
          rrt_reg[s] <= clamp_rank(i_wdata[4:0], count_reg);
        end
        if (hit(i_addr, `PSDT_OFS_EXIT_LATENCY_US)) begin
          exit_latency_us_reg[s] <= i_wdata;
        end
        if (hit(i_addr, `PSDT_OFS_ENTRY_LATENCY_US)) begin
          entry_latency_us_reg[s] <= i_wdata;
        end
        if (hit(i_addr, `PSDT_OFS_POWER)) begin
          non_operational_flag_reg[s] <= i_wdata[`PSDT_PWR_NON_OPERATIONAL_FLAG_BIT];
          mps_reg[s] <= i_wdata[`PSDT_PWR_MPS_BIT];
          mp_reg[s] <= i_wdata[15:0];
        end
      end
    end
  end

  // software view: descriptor of the selected state
  psdt_desc_pack u_sw_pack (
    .i_rwl(rwl_reg[sel_reg]),
    .i_rwt(rwt_reg[sel_reg]),
    .i_rrl(rrl_reg[sel_reg]),
    .i_rrt(rrt_reg[sel_reg]),
    .i_exit_latency_us(exit_latency_us_reg[sel_reg]),
    .i_entry_latency_us(entry_latency_us_reg[sel_reg]),
    .i_non_operational_flag(non_operational_flag_reg[sel_reg]),
    .i_mps(mps_reg[sel_reg]),
    .i_mp(mp_reg[sel_reg]),
    .i_valid({1'b0, sel_reg} < count_reg),
    .o_desc(sw_desc)
  );

  // host view: unsupported states give an all-zero descriptor
  psdt_desc_pack u_host_pack (
    .i_rwl(rwl_reg[i_desc_idx]),
    .i_rwt(rwt_reg[i_desc_idx]),
    .i_rrl(rrl_reg[i_desc_idx]),
    .i_rrt(rrt_reg[i_desc_idx]),
    .i_exit_latency_us(exit_latency_us_reg[i_desc_idx]),
    .i_entry_latency_us(entry_latency_us_reg[i_desc_idx]),
    .i_non_operational_flag(non_operational_flag_reg[i_desc_idx]),
    .i_mps(mps_reg[i_desc_idx]),
    .i_mp(mp_reg[i_desc_idx]),
    .i_valid({1'b0, i_desc_idx} < count_reg),
    .o_desc(host_desc)
  );

  // host descriptor registered, one cycle after the index
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      desc_reg <= '0;
    end else if (i_ce) begin
      desc_reg <= host_desc;
    end
  end

  // io gating follows the flag of the state the controller sits in
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      io_blk_reg <= 1'b0;
    end else if (i_ce) begin
      io_blk_reg <= ({1'b0, i_cur_state} < count_reg) &&
                    non_operational_flag_reg[i_cur_state];
    end
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_reg <= 32'h0;
    end else if (i_ce) begin
      rdata_reg <= 32'h0;
      if (i_rd) begin
        case (i_addr)
          `PSDT_OFS_SEL: rdata_reg <= {27'h0, sel_reg};
          `PSDT_OFS_RANK: rdata_reg <= {3'h0, sw_desc[124:120],
                                        3'h0, sw_desc[116:112],
                                        3'h0, sw_desc[108:104],
                                        3'h0, sw_desc[100:96]};
          `PSDT_OFS_EXIT_LATENCY_US: rdata_reg <= sw_desc[95:64];
          `PSDT_OFS_ENTRY_LATENCY_US: rdata_reg <= sw_desc[63:32];
          `PSDT_OFS_POWER: rdata_reg <= {14'h0, sw_desc[25:24],
                                         sw_desc[15:0]};
          `PSDT_OFS_COUNT: rdata_reg <= {26'h0, count_reg};
          `PSDT_OFS_RDSEL: rdata_reg <= {29'h0, rdsel_reg};
          `PSDT_OFS_RDDAT: rdata_reg <= sw_desc[32*rdsel_reg +: 32];
          `PSDT_OFS_STAT: rdata_reg <= {31'h0, clamp_reg};
          default: rdata_reg <= 32'h0; // unmapped reads zero
        endcase
      end
    end
  end

  assign o_rdata = rdata_reg;
  assign o_desc = desc_reg;
  assign o_io_blocked = io_blk_reg;

  // a write to the watched state lands on the same edge that registers the
  // old fields, so the placement checks skip that one cycle
  logic wr_at_desc;
  logic wr_at_cur;
  assign wr_at_desc = i_wr && (sel_reg == i_desc_idx);
  assign wr_at_cur = i_wr && (sel_reg == i_cur_state);

  // checks
  chk_rank_bound: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    ({1'b0, o_desc[124:120]} < count_reg) &&
    ({1'b0, o_desc[116:112]} < count_reg) &&
    ({1'b0, o_desc[108:104]} < count_reg) &&
    ({1'b0, o_desc[100:96]} < count_reg))
    else $error("rank not below state count");
  chk_reserved_zero: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_desc[255:125] == '0 && o_desc[119:117] == '0 &&
    o_desc[111:109] == '0 && o_desc[103:101] == '0 &&
    o_desc[31:26] == '0 && o_desc[23:16] == '0)
    else $error("reserved descriptor bits not zero");
  chk_unsup_zero: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && {1'b0, i_desc_idx} >= count_reg |=> o_desc == '0)
    else $error("unsupported state descriptor not zero");
  chk_wl_place: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && {1'b0, i_desc_idx} < count_reg && !wr_at_desc
    |=> o_desc[124:120] == rwl_reg[$past(i_desc_idx)])
    else $error("write latency rank misplaced");
  chk_wt_place: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && {1'b0, i_desc_idx} < count_reg && !wr_at_desc
    |=> o_desc[116:112] == rwt_reg[$past(i_desc_idx)])
    else $error("write throughput rank misplaced");
  chk_rl_place: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && {1'b0, i_desc_idx} < count_reg && !wr_at_desc
    |=> o_desc[108:104] == rrl_reg[$past(i_desc_idx)])
    else $error("read latency rank misplaced");
  chk_rt_place: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && {1'b0, i_desc_idx} < count_reg && !wr_at_desc
    |=> o_desc[100:96] == rrt_reg[$past(i_desc_idx)])
    else $error("read throughput rank misplaced");
  chk_exit_latency_us_write: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && i_wr && i_addr == `PSDT_OFS_EXIT_LATENCY_US && !i_rd ##1
    i_ce && i_rd && i_addr == `PSDT_OFS_EXIT_LATENCY_US && !i_wr &&
    {1'b0, sel_reg} < count_reg
    |=> o_rdata == $past(i_wdata, 2))
    else $error("exit latency not reported");
  chk_entry_latency_us_write: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && i_wr && i_addr == `PSDT_OFS_ENTRY_LATENCY_US ##1
    i_ce && i_rd && i_addr == `PSDT_OFS_ENTRY_LATENCY_US && {1'b0, sel_reg} < count_reg
    |=> o_rdata == $past(i_wdata, 2))
    else $error("entry latency not reported");
  chk_io_block: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && {1'b0, i_cur_state} < count_reg && !wr_at_cur
    |=> o_io_blocked == non_operational_flag_reg[$past(i_cur_state)])
    else $error("io gating differs from state flag");
  chk_power_bits: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && {1'b0, i_desc_idx} < count_reg && !wr_at_desc |=>
    o_desc[24] == mps_reg[$past(i_desc_idx)] &&
    o_desc[15:0] == mp_reg[$past(i_desc_idx)])
    else $error("power fields misplaced");
  chk_rd_one_cycle: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && !i_rd |=> o_rdata == 32'h0)
    else $error("read data outside answer cycle");
  cov_clamp: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    $rose(clamp_reg));
  cov_io_block: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    $rose(o_io_blocked));
  cov_last_desc: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    i_desc_idx == 5'h1f && count_reg == 6'h20);
endmodule : psdt_table

// File: tb/psdt_host_model.sv
// Purpose: host side that fetches one descriptor and the io flag
// Assumes: the table samples the index on the edge after it changes
// Notes: the index is a level and holds between fetches, like a host
`timescale 1ns/1ns
module psdt_host_model (
  // clock
  input wire logic i_clk,
  // fetch request from the bench
  input wire logic i_req,
  input wire logic [4:0] i_req_idx,
  // table side
  input wire logic [255:0] i_desc,
  input wire logic i_blocked,
  output logic [4:0] o_idx,
  // captured result, o_got high for one cycle
  output logic o_got,
  output logic [255:0] o_desc,
  output logic o_blocked
);
  logic [1:0] ph_reg;
  initial begin
    o_idx = 5'h00;
    o_got = 1'b0;
    ph_reg = 2'h0;
  end
  // set index, let the table sample it, capture on the edge after
  always @(posedge i_clk) begin
    o_got <= 1'b0;
    if (i_req) begin
      o_idx <= i_req_idx;
      ph_reg <= 2'h1;
    end else if (ph_reg == 2'h1) begin
      ph_reg <= 2'h2;
    end else if (ph_reg == 2'h2) begin
      o_desc <= i_desc;
      o_blocked <= i_blocked;
      o_got <= 1'b1;
      ph_reg <= 2'h0;
    end
  end
endmodule : psdt_host_model

// File: tb/psdt_table_bench.sv
// Purpose: self-checking bench for the descriptor table
// Assumes: register reads answer in the cycle after the strobe
// Notes: expected words and descriptors are queued by the drivers
`timescale 1ns/1ns
`include "psdt_defs.svh"
module psdt_table_bench;
  import psdt_pkg::*;
  logic i_clk, i_rst_n, i_wr, i_rd, req, got, blk, o_io_blocked, rd_seen;
  logic [7:0] i_addr;
  logic [31:0] i_wdata, o_rdata, lfsr, cnt;
  logic [4:0] req_idx;
  psdt_idx_t idx;
  psdt_desc_t o_desc, got_desc, exp_d[32];
  logic [31:0] rd_q[$];
  psdt_desc_t d_q[$];
  int n_errors, checks_done, cyc;
  logic sticky, ce;
  psdt_table psdt_table_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(ce),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_desc_idx(idx), .o_desc(o_desc),
    .i_cur_state(idx), .o_io_blocked(o_io_blocked));
  psdt_host_model psdt_host_model_i (.i_clk(i_clk), .i_req(req),
    .i_req_idx(req_idx), .i_desc(o_desc), .i_blocked(o_io_blocked),
    .o_idx(idx), .o_got(got), .o_desc(got_desc), .o_blocked(blk));
  // clock, 10 ns period
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], 1'b0} ^ (v[31] ? 32'h04c11db7 : 32'h00000000);
  endfunction : nxt
  // clamp as the table does, remembering that a clamp happened
  function automatic logic [4:0] cl(input logic [4:0] v);
    if (v >= cnt) begin
      sticky = 1'b1;
      return 5'(cnt - 1);
    end
    return v;
  endfunction : cl
  task automatic cmp(input logic [255:0] g, input logic [255:0] e);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("FAIL t=%0t got %h exp %h", $time, g, e);
    end
  endtask : cmp
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
  endtask : rd
  // write then read the same address with no idle cycle between
  task automatic wr_rd(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
    i_rd <= 1'b1;
    rd_q.push_back(d);
    @(posedge i_clk);
    i_rd <= 1'b0;
  endtask : wr_rd
  task automatic fetch(input logic [4:0] s);
    d_q.push_back(exp_d[s]);
    @(posedge i_clk);
    req <= 1'b1;
    req_idx <= s;
    @(posedge i_clk);
    req <= 1'b0;
    repeat (3) @(posedge i_clk);
  endtask : fetch
  // program state s with random fields, then read all eight words back
  task automatic prog(input logic [4:0] s);
    logic [4:0] wl, wt, rl, rt;
    logic [31:0] ex, en, pw;
    lfsr = nxt(lfsr);
    wl = cl(lfsr[4:0]);
    wt = cl(lfsr[9:5]);
    rl = cl(lfsr[14:10]);
    rt = cl(lfsr[19:15]);
    wr(`PSDT_OFS_SEL, {27'h0, s});
    wr(`PSDT_OFS_RANK, {3'h0, lfsr[4:0], 3'h0, lfsr[9:5], 3'h0,
      lfsr[14:10], 3'h0, lfsr[19:15]});
    lfsr = nxt(lfsr);
    ex = lfsr;
    lfsr = nxt(lfsr);
    en = lfsr;
    lfsr = nxt(lfsr);
    pw = lfsr & 32'h0003ffff;
    wr(`PSDT_OFS_EXIT_LATENCY_US, ex);
    wr(`PSDT_OFS_ENTRY_LATENCY_US, en);
    wr(`PSDT_OFS_POWER, pw);
    exp_d[s] = {131'h0, wl, 3'h0, wt, 3'h0, rl, 3'h0, rt, ex, en, 6'h0,
      pw[17], pw[16], 8'h0, pw[15:0]};
    for (int k = 0; k < 8; k++) begin
      wr(`PSDT_OFS_RDSEL, k);
      rd(`PSDT_OFS_RDDAT, exp_d[s][32*k+:32]);
    end
  endtask : prog
  task automatic give_verdict;
    if (n_errors == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : give_verdict
  // watcher: read data stands one cycle after the strobe, fetches on got
  always @(posedge i_clk) begin
    rd_seen <= i_rd;
    if (rd_seen) cmp(o_rdata, rd_q.pop_front());
    if (got) begin
      cmp(got_desc, d_q[0]);
      cmp(blk, d_q[0][25]);
      void'(d_q.pop_front());
    end
  end
  // hang guard, well above the few hundred cycles the run needs
  always @(posedge i_clk) begin
    cyc++;
    if (cyc > 20000) begin
      n_errors++;
      give_verdict();
    end
  end
  initial begin
    {i_wr, i_rd, req, sticky} = 4'h0;
    ce = 1'b1;
    {n_errors, checks_done, cyc} = 0;
    i_addr = 8'h00;
    i_wdata = 32'h0;
    req_idx = 5'h00;
    lfsr = 32'h46f0a149;
    cnt = 32'd1;
    for (int s = 0; s < 32; s++) exp_d[s] = '0;
    i_rst_n = 1'b0;
    repeat (8) @(posedge i_clk);
    i_rst_n <= 1'b1;
    // reset defaults and an unmapped address
    rd(`PSDT_OFS_COUNT, 32'h1);
    rd(`PSDT_OFS_STAT, 32'h0);
    rd(8'hfc, 32'h0);
    fetch(5'h00);
    // six states, ranks clamped below the count
    cnt = 32'd6;
    wr(`PSDT_OFS_COUNT, cnt);
    for (int s = 0; s < 6; s++) prog(5'(s));
    rd(`PSDT_OFS_STAT, {31'h0, sticky});
    wr(`PSDT_OFS_STAT, 32'h1);
    rd(`PSDT_OFS_STAT, 32'h0);
    for (int s = 0; s < 8; s++) fetch(5'(s));
    // a write to an unsupported state stays hidden
    prog_hidden: begin
      wr(`PSDT_OFS_SEL, 32'd20);
      wr(`PSDT_OFS_POWER, 32'h00020001);
      fetch(5'd20);
    end
    // full table, last descriptor and back to back fetches
    cnt = 32'd32;
    wr(`PSDT_OFS_COUNT, cnt);
    prog(5'd31);
    fetch(5'd31);
    fetch(5'd0);
    // back to back write and read, then a write ignored while frozen
    lfsr = nxt(lfsr);
    wr_rd(`PSDT_OFS_EXIT_LATENCY_US, lfsr);
    lfsr = nxt(lfsr);
    wr_rd(`PSDT_OFS_ENTRY_LATENCY_US, lfsr);
    ce <= 1'b0;
    wr(`PSDT_OFS_COUNT, 32'h5);
    ce <= 1'b1;
    rd(`PSDT_OFS_COUNT, 32'h20);
    repeat (4) @(posedge i_clk);
    give_verdict();
  end
endmodule : psdt_table_bench
